// ===== hw/motion_pkg.sv
// Purpose: Shared types and constants for the indexer motion command block.
// Assumes: Commands arrive already parsed as one-cycle strobes.
// Notes: Speeds are in steps per second; one step per speed period.
package motion_pkg;

  // ==========================================================
  // Widths and limits
  localparam int SPEED_W = 15;
  localparam logic [SPEED_W-1:0] SPEED_LIMIT = 15'h4E20;
  localparam logic [7:0] AMP_MAX = 8'hFF;
  localparam logic [9:0] AMP_LIMIT = 10'h0FF;
  localparam logic [7:0] OUT_IDLE = 8'hFF;
  localparam logic [31:0] CLOCK_HZ = 32'h05F5E100;
  localparam logic [15:0] PROFILE_CYCLES = 16'h0040;
  localparam logic [31:0] RAMP_STEP = 32'h00000001;

  // ==========================================================
  // Error codes
  localparam logic [1:0] ERR_SYNTAX = 2'h0;
  localparam logic [1:0] ERR_RANGE = 2'h1;
  localparam logic [1:0] ERR_NO_CURRENT = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PROFILE = 3'b001,
    ST_RUN = 3'b010,
    ST_DECEL = 3'b011
  } motion_state_t;

  typedef enum logic [1:0] {
    DIR_ANY = 2'b00,
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } pass_dir_t;

  typedef struct packed {
    logic has_speed;
    logic has_sign;
    logic sign_neg;
    logic [SPEED_W-1:0] speed;
  } run_req_t;

  typedef struct packed {
    logic valid_hex;
    logic [9:0] pattern;
    logic [7:0] mask;
    logic option_bad;
    logic deferred;
    logic relative;
    pass_dir_t pass_dir;
    logic [31:0] position;
  } out_req_t;

  typedef struct packed {
    logic present;
    logic numeric;
    logic negative;
    logic [9:0] amplitude;
  } amp_req_t;

endpackage

// ===== hw/stepper_indexer_motion.sv
// Purpose: Executes infinite runs, homing, stops, current and outputs.
// Assumes: Command fields are valid in the cycle of their strobe.
// Notes: The step pulse rate follows the current speed, one step per
// period; the counter moves one count per step, except a step issued
// in the cycle of an immediate stop or master reset.
`timescale 1ns/1ps

module stepper_indexer_motion
  import motion_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Configuration
  input wire logic MICROSTEP,
  input wire logic CURRENT_PROGRAMMABLE,
  input wire logic FACTORY_RESTORE,
  input wire logic [SPEED_W-1:0] MAX_SPEED_SETTING,
  input wire logic [SPEED_W-1:0] MIN_SPEED_SETTING,
  input wire logic SPEED_CHANGED,
  // Commands
  input wire logic INFINITE_RUN_CMD,
  input wire run_req_t RUN_REQ,
  input wire logic RETURN_HOME_CMD,
  input wire logic DECELERATING_STOP_CMD,
  input wire logic IMMEDIATE_STOP_CMD,
  input wire logic MASTER_RESET_CMD,
  input wire logic CURRENT_AMPLITUDE_CMD,
  input wire amp_req_t AMP_REQ,
  input wire logic OUTPUT_PATTERN_CMD,
  input wire out_req_t OUT_REQ,
  input wire logic MOTOR_POWER_ON_CMD,
  input wire logic MOTOR_POWER_OFF_CMD,
  // Answers
  output logic CMD_ERROR,
  output logic [1:0] ERROR_CODE,
  output logic CMD_REFUSED,
  // Motor side
  output logic STEP,
  output logic DIRECTION_NEG,
  output logic MOVING,
  output logic MOTOR_POWER,
  output logic STANDBY_CURRENT,
  output logic [7:0] CURRENT_AMPLITUDE,
  output logic [SPEED_W-1:0] SPEED,
  output logic signed [31:0] ABSOLUTE_STEP_COUNTER,
  output logic [7:0] OUTPUTS_N
);

  motion_state_t state;
  logic [SPEED_W-1:0] target;
  logic infinite;
  logic homing;
  logic profile_stale;
  logic [15:0] prof_cnt;
  logic [31:0] step_acc;
  logic step_now;
  logic run_ok;
  logic busy;
  logic any_stop;
  logic [SPEED_W-1:0] run_speed;
  logic run_dir_neg;
  logic out_armed;
  logic [7:0] arm_pattern;
  logic [7:0] arm_mask;
  pass_dir_t arm_dir;
  logic signed [31:0] arm_pos;
  logic out_fire;
  logic move_end;

  assign busy = (state != ST_IDLE);
  assign any_stop = IMMEDIATE_STOP_CMD | MASTER_RESET_CMD;
  assign MOVING = busy;

  // ==========================================================
  // Command decode
  always_comb begin
    run_speed = MAX_SPEED_SETTING;
    if (RUN_REQ.has_speed && RUN_REQ.speed == '0) begin
      run_speed = MIN_SPEED_SETTING;
    end else if (RUN_REQ.has_speed) begin
      run_speed = RUN_REQ.speed;
    end
    run_dir_neg = DIRECTION_NEG;
    if (RUN_REQ.has_sign && !(busy && MICROSTEP)) begin
      run_dir_neg = RUN_REQ.sign_neg;
    end
  end

  // A microstep run while moving must replace an infinite run.
  assign run_ok = !busy || (MICROSTEP && infinite);
  assign out_fire = out_armed && step_now && (arm_pos ==
      (DIRECTION_NEG ? ABSOLUTE_STEP_COUNTER - 32'sd1
                     : ABSOLUTE_STEP_COUNTER + 32'sd1)) &&
      (arm_dir == DIR_ANY ||
       (arm_dir == DIR_UP && !DIRECTION_NEG) ||
       (arm_dir == DIR_DOWN && DIRECTION_NEG));

  // ==========================================================
  // Motion state machine
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      target <= '0;
      infinite <= 1'b0;
      homing <= 1'b0;
      DIRECTION_NEG <= 1'b0;
      SPEED <= '0;
      prof_cnt <= '0;
      move_end <= 1'b0;
    end else begin
      move_end <= 1'b0;
      if (any_stop) begin
        state <= ST_IDLE;
        SPEED <= '0;
        infinite <= 1'b0;
        homing <= 1'b0;
        move_end <= busy;
      end else begin
        case (state)
          ST_IDLE: begin
            if (INFINITE_RUN_CMD && !(MICROSTEP && RUN_REQ.has_speed &&
                RUN_REQ.speed >= SPEED_LIMIT)) begin
              target <= run_speed;
              DIRECTION_NEG <= run_dir_neg;
              infinite <= 1'b1;
              prof_cnt <= PROFILE_CYCLES;
              state <= ST_PROFILE;
            end else if (RETURN_HOME_CMD &&
                ABSOLUTE_STEP_COUNTER != 32'sd0) begin
              target <= MAX_SPEED_SETTING;
              DIRECTION_NEG <= (ABSOLUTE_STEP_COUNTER > 32'sd0);
              homing <= 1'b1;
              prof_cnt <= PROFILE_CYCLES;
              state <= ST_PROFILE;
            end
          end
          ST_PROFILE: begin
            // Recompute only after reset or when a speed setting moved, else skip.
            if (DECELERATING_STOP_CMD) begin
              // Not yet stepping, so this is below minimum speed.
              state <= ST_IDLE;
              infinite <= 1'b0;
              homing <= 1'b0;
              move_end <= 1'b1;
            end else if (!profile_stale || prof_cnt == 16'h0000) begin
              SPEED <= MIN_SPEED_SETTING;
              state <= ST_RUN;
            end else begin
              prof_cnt <= prof_cnt - 16'h0001;
            end
          end
          ST_RUN: begin
            if (DECELERATING_STOP_CMD) begin
              if (SPEED <= MIN_SPEED_SETTING) begin
                state <= ST_IDLE;
                SPEED <= '0;
                infinite <= 1'b0;
                move_end <= 1'b1;
              end else begin
                state <= ST_DECEL;
              end
            end else if (INFINITE_RUN_CMD && run_ok) begin
              target <= run_speed;
            end else if (homing && step_now &&
                ABSOLUTE_STEP_COUNTER == (DIRECTION_NEG ? 32'sd1
                                                        : -32'sd1)) begin
              state <= ST_IDLE;
              SPEED <= '0;
              homing <= 1'b0;
              move_end <= 1'b1;
            end else if (step_now && SPEED < target) begin
              SPEED <= SPEED + SPEED_W'(RAMP_STEP);
            end else if (step_now && SPEED > target) begin
              SPEED <= SPEED - SPEED_W'(RAMP_STEP);
            end
          end
          ST_DECEL: begin
            if (SPEED <= MIN_SPEED_SETTING) begin
              state <= ST_IDLE;
              SPEED <= '0;
              infinite <= 1'b0;
              homing <= 1'b0;
              move_end <= 1'b1;
            end else if (step_now) begin
              SPEED <= SPEED - SPEED_W'(RAMP_STEP);
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Acceleration profile staleness
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      profile_stale <= 1'b1;
    end else if (SPEED_CHANGED) begin
      profile_stale <= 1'b1;
    end else if (state == ST_PROFILE && prof_cnt == 16'h0000) begin
      profile_stale <= 1'b0;
    end
  end

  // ==========================================================
  // Step generator: phase accumulator at SPEED steps per second
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      step_acc <= '0;
      STEP <= 1'b0;
    end else if (state == ST_RUN || state == ST_DECEL) begin
      if (step_acc + 32'(SPEED) >= CLOCK_HZ) begin
        step_acc <= step_acc + 32'(SPEED) - CLOCK_HZ;
        STEP <= 1'b1;
      end else begin
        step_acc <= step_acc + 32'(SPEED);
        STEP <= 1'b0;
      end
    end else begin
      step_acc <= '0;
      STEP <= 1'b0;
    end
  end
  assign step_now = (state == ST_RUN || state == ST_DECEL) &&
      (step_acc + 32'(SPEED) >= CLOCK_HZ);

  // ==========================================================
  // Absolute step counter
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ABSOLUTE_STEP_COUNTER <= '0;
    end else if (MASTER_RESET_CMD) begin
      ABSOLUTE_STEP_COUNTER <= '0;
    end else if (step_now && !any_stop) begin
      ABSOLUTE_STEP_COUNTER <= DIRECTION_NEG ?
          ABSOLUTE_STEP_COUNTER - 32'sd1 : ABSOLUTE_STEP_COUNTER + 32'sd1;
    end
  end

  // ==========================================================
  // Motor power and current
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      MOTOR_POWER <= 1'b0;
    end else if (MOTOR_POWER_OFF_CMD) begin
      MOTOR_POWER <= 1'b0;
    end else if (MOTOR_POWER_ON_CMD || (state == ST_IDLE && !any_stop &&
        ((INFINITE_RUN_CMD) ||
         (RETURN_HOME_CMD && ABSOLUTE_STEP_COUNTER != 32'sd0)))) begin
      MOTOR_POWER <= 1'b1;
    end
  end

  // Full/half step: standby follows output bit 0; microstep: motion.
  assign STANDBY_CURRENT = MICROSTEP ? !busy : OUTPUTS_N[0];

  // Amplitude survives master reset; only factory restore or RST clears it.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CURRENT_AMPLITUDE <= '0;
    end else if (FACTORY_RESTORE) begin
      CURRENT_AMPLITUDE <= '0;
    end else if (CURRENT_AMPLITUDE_CMD && CURRENT_PROGRAMMABLE &&
        AMP_REQ.present && AMP_REQ.numeric && !AMP_REQ.negative &&
        AMP_REQ.amplitude <= AMP_LIMIT) begin
      CURRENT_AMPLITUDE <= AMP_REQ.amplitude[7:0];
    end
  end

  // ==========================================================
  // Logical outputs, active low
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      OUTPUTS_N <= OUT_IDLE;
      out_armed <= 1'b0;
      arm_pattern <= '0;
      arm_mask <= '0;
      arm_dir <= DIR_ANY;
      arm_pos <= '0;
    end else if (MASTER_RESET_CMD) begin
      OUTPUTS_N <= OUT_IDLE;
      out_armed <= 1'b0;
    end else if (!MICROSTEP && move_end) begin
      OUTPUTS_N <= OUT_IDLE;
    end else if (OUTPUT_PATTERN_CMD && OUT_REQ.valid_hex &&
        OUT_REQ.pattern <= AMP_LIMIT && !OUT_REQ.option_bad) begin
      if (MICROSTEP && OUT_REQ.deferred) begin
        out_armed <= 1'b1;
        arm_pattern <= OUT_REQ.pattern[7:0];
        arm_mask <= OUT_REQ.mask;
        arm_dir <= OUT_REQ.pass_dir;
        arm_pos <= OUT_REQ.relative ?
            ABSOLUTE_STEP_COUNTER + OUT_REQ.position : OUT_REQ.position;
      end else begin
        OUTPUTS_N <= (OUTPUTS_N & ~OUT_REQ.mask) |
            (OUT_REQ.pattern[7:0] & OUT_REQ.mask);
      end
    end else if (out_fire) begin
      OUTPUTS_N <= (OUTPUTS_N & ~arm_mask) |
          (arm_pattern & arm_mask);
      out_armed <= 1'b0;
    end
  end

  // ==========================================================
  // Error and refusal answers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CMD_ERROR <= 1'b0;
      ERROR_CODE <= ERR_SYNTAX;
      CMD_REFUSED <= 1'b0;
    end else begin
      CMD_ERROR <= 1'b0;
      CMD_REFUSED <= 1'b0;
      ERROR_CODE <= ERR_SYNTAX;
      if (CURRENT_AMPLITUDE_CMD) begin
        if (MICROSTEP && !CURRENT_PROGRAMMABLE) begin
          CMD_ERROR <= 1'b1;
          ERROR_CODE <= ERR_NO_CURRENT;
        end else if (!AMP_REQ.present || !AMP_REQ.numeric ||
            AMP_REQ.negative) begin
          CMD_ERROR <= 1'b1;
        end else if (AMP_REQ.amplitude > AMP_LIMIT) begin
          CMD_ERROR <= 1'b1;
          ERROR_CODE <= ERR_RANGE;
        end
      end else if (OUTPUT_PATTERN_CMD) begin
        if (!OUT_REQ.valid_hex) begin
          CMD_ERROR <= 1'b1;
        end else if (OUT_REQ.pattern > AMP_LIMIT || OUT_REQ.option_bad) begin
          CMD_ERROR <= 1'b1;
          ERROR_CODE <= ERR_RANGE;
        end
      end else if (INFINITE_RUN_CMD) begin
        if (MICROSTEP && RUN_REQ.has_speed &&
            RUN_REQ.speed >= SPEED_LIMIT) begin
          CMD_ERROR <= 1'b1;
          ERROR_CODE <= ERR_RANGE;
        end else if (!run_ok) begin
          CMD_REFUSED <= 1'b1;
        end
      end
    end
  end

endmodule // stepper_indexer_motion

// ===== bench/motion_props.sv
// Purpose: Port assertions for the motion command block.
// Assumes: One clock domain, reset asynchronous and active high.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
module motion_props
  import motion_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Inputs watched
  input wire logic MICROSTEP,
  input wire logic CURRENT_PROGRAMMABLE,
  input wire logic FACTORY_RESTORE,
  input wire logic [SPEED_W-1:0] MIN_SPEED_SETTING,
  input wire logic INFINITE_RUN_CMD,
  input wire run_req_t RUN_REQ,
  input wire logic RETURN_HOME_CMD,
  input wire logic DECELERATING_STOP_CMD,
  input wire logic IMMEDIATE_STOP_CMD,
  input wire logic MASTER_RESET_CMD,
  input wire logic CURRENT_AMPLITUDE_CMD,
  input wire amp_req_t AMP_REQ,
  input wire logic OUTPUT_PATTERN_CMD,
  input wire out_req_t OUT_REQ,
  // Outputs watched
  input wire logic CMD_ERROR,
  input wire logic [1:0] ERROR_CODE,
  input wire logic MOVING,
  input wire logic MOTOR_POWER,
  input wire logic STANDBY_CURRENT,
  input wire logic [7:0] CURRENT_AMPLITUDE,
  input wire logic [SPEED_W-1:0] SPEED,
  input wire logic signed [31:0] ABSOLUTE_STEP_COUNTER,
  input wire logic [7:0] OUTPUTS_N
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // ==========================================================
  // Qualifiers
  // Immediate stop and master reset outrank run commands in the same cycle; only master reset outranks output commands.
  logic halt;
  logic amp_ok;
  logic out_ok;
  logic run_ok;
  assign halt = DECELERATING_STOP_CMD | IMMEDIATE_STOP_CMD | MASTER_RESET_CMD;
  assign amp_ok = CURRENT_AMPLITUDE_CMD & CURRENT_PROGRAMMABLE
    & AMP_REQ.present & AMP_REQ.numeric & !AMP_REQ.negative
    & !FACTORY_RESTORE;
  assign out_ok = OUTPUT_PATTERN_CMD & OUT_REQ.valid_hex
    & !OUT_REQ.option_bad & !OUT_REQ.deferred & !halt;
  assign run_ok = INFINITE_RUN_CMD & MICROSTEP & !MOVING & !halt
    & (!RUN_REQ.has_speed
    | (RUN_REQ.speed != '0 & RUN_REQ.speed < SPEED_LIMIT));
  // ==========================================================
  // Assertions
  amp_set_a: assert property (amp_ok && AMP_REQ.amplitude <= AMP_LIMIT
    |=> CURRENT_AMPLITUDE == $past(AMP_REQ.amplitude[7:0]))
    else $error("amplitude not taken");
  amp_range_a: assert property (amp_ok && AMP_REQ.amplitude > AMP_LIMIT
    |=> CMD_ERROR && ERROR_CODE == ERR_RANGE)
    else $error("amplitude range error missing");
  no_current_a: assert property (
    CURRENT_AMPLITUDE_CMD && !CURRENT_PROGRAMMABLE && MICROSTEP
    |=> CMD_ERROR && ERROR_CODE == ERR_NO_CURRENT)
    else $error("indexer-only error missing");
  out_mask_a: assert property (out_ok && OUT_REQ.pattern <= 10'h0FF
    |=> OUTPUTS_N == (($past(OUTPUTS_N) & ~$past(OUT_REQ.mask))
    | ($past(OUT_REQ.pattern[7:0]) & $past(OUT_REQ.mask))))
    else $error("masked output update wrong");
  out_range_a: assert property (out_ok && OUT_REQ.pattern > 10'h0FF
    |=> CMD_ERROR && ERROR_CODE == ERR_RANGE)
    else $error("pattern range error missing");
  stop_now_a: assert property (IMMEDIATE_STOP_CMD |=> !MOVING)
    else $error("immediate stop late");
  auto_power_a: assert property (run_ok |=> MOVING && MOTOR_POWER)
    else $error("run did not power motor");
  home_zero_a: assert property (
    RETURN_HOME_CMD && ABSOLUTE_STEP_COUNTER == 0 && !MOVING && !halt
    |=> !MOVING [*3])
    else $error("home at origin moved");
  decel_min_a: assert property (
    DECELERATING_STOP_CMD && MOVING && SPEED <= MIN_SPEED_SETTING
    |-> ##[1:2] !MOVING)
    else $error("stop at minimum speed ramped");
  standby_a: assert property (
    MOTOR_POWER && MICROSTEP |-> STANDBY_CURRENT == !MOVING)
    else $error("standby current wrong");
endmodule // motion_props

bind stepper_indexer_motion motion_props motion_props_inst (
  .CLOCK(CLOCK), .RST(RST), .MICROSTEP(MICROSTEP),
  .CURRENT_PROGRAMMABLE(CURRENT_PROGRAMMABLE),
  .FACTORY_RESTORE(FACTORY_RESTORE),
  .MIN_SPEED_SETTING(MIN_SPEED_SETTING),
  .INFINITE_RUN_CMD(INFINITE_RUN_CMD), .RUN_REQ(RUN_REQ),
  .RETURN_HOME_CMD(RETURN_HOME_CMD),
  .DECELERATING_STOP_CMD(DECELERATING_STOP_CMD),
  .IMMEDIATE_STOP_CMD(IMMEDIATE_STOP_CMD),
  .MASTER_RESET_CMD(MASTER_RESET_CMD),
  .CURRENT_AMPLITUDE_CMD(CURRENT_AMPLITUDE_CMD), .AMP_REQ(AMP_REQ),
  .OUTPUT_PATTERN_CMD(OUTPUT_PATTERN_CMD), .OUT_REQ(OUT_REQ),
  .CMD_ERROR(CMD_ERROR), .ERROR_CODE(ERROR_CODE), .MOVING(MOVING),
  .MOTOR_POWER(MOTOR_POWER), .STANDBY_CURRENT(STANDBY_CURRENT),
  .CURRENT_AMPLITUDE(CURRENT_AMPLITUDE), .SPEED(SPEED),
  .ABSOLUTE_STEP_COUNTER(ABSOLUTE_STEP_COUNTER), .OUTPUTS_N(OUTPUTS_N)
);

// ===== bench/motor_model.sv
// Purpose: Motor side model that tracks shaft position from step pulses.
// Assumes: One step per clock cycle with STEP high.
// Notes: Master reset makes the present shaft position the origin.
`timescale 1ns/1ps
module motor_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Drive from the block
  input wire logic step,
  input wire logic dir_neg,
  input wire logic origin_clear,
  // Observed position
  output int pos
);
  always_ff @(posedge clock or posedge rst) begin
    if (rst || origin_clear) begin
      pos <= 0;
    end else if (step) begin
      pos <= dir_neg ? pos - 1 : pos + 1;
    end
  end
endmodule // motor_model

// ===== bench/stepper_indexer_motion_commands_test.sv
// Purpose: Self-checking bench for the motion command block.
// Assumes: Commands are one-cycle strobes launched on a rising edge.
// Notes: Speeds sit near the limit, so a step takes about 5000 cycles.
`timescale 1ns/1ps
module stepper_indexer_motion_commands_test;
  import motion_pkg::*;
  localparam int RUN = 0, HOME = 1, DEC = 2, STOP = 3, MRST = 4;
  localparam int AMP = 5, OUT = 6, PON = 7, POFF = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ms = 1'b1, cp = 1'b1, fr = 1'b0, sc = 1'b0;
  logic [8:0] st = '0;
  run_req_t rr = '0;
  amp_req_t ar = '0;
  out_req_t orq = '0;
  logic err, refused, step, dneg, moving, power, stby;
  logic [1:0] code;
  logic [7:0] amp, outs;
  logic [SPEED_W-1:0] speed;
  logic signed [31:0] absolute_step_counter;
  int pos;
  int bad_count = 0, total_checks = 0, cyc = 0;
  always #5 clock = ~clock;
  // ==========================================================
  // Block and motor
  stepper_indexer_motion stepper_indexer_motion_inst (
    .CLOCK(clock), .RST(rst), .MICROSTEP(ms),
    .CURRENT_PROGRAMMABLE(cp), .FACTORY_RESTORE(fr),
    .MAX_SPEED_SETTING(15'h4E1F), .MIN_SPEED_SETTING(15'h4E16),
    .SPEED_CHANGED(sc), .INFINITE_RUN_CMD(st[RUN]), .RUN_REQ(rr),
    .RETURN_HOME_CMD(st[HOME]), .DECELERATING_STOP_CMD(st[DEC]),
    .IMMEDIATE_STOP_CMD(st[STOP]), .MASTER_RESET_CMD(st[MRST]),
    .CURRENT_AMPLITUDE_CMD(st[AMP]), .AMP_REQ(ar),
    .OUTPUT_PATTERN_CMD(st[OUT]), .OUT_REQ(orq),
    .MOTOR_POWER_ON_CMD(st[PON]), .MOTOR_POWER_OFF_CMD(st[POFF]),
    .CMD_ERROR(err), .ERROR_CODE(code), .CMD_REFUSED(refused),
    .STEP(step), .DIRECTION_NEG(dneg), .MOVING(moving),
    .MOTOR_POWER(power), .STANDBY_CURRENT(stby),
    .CURRENT_AMPLITUDE(amp), .SPEED(speed),
    .ABSOLUTE_STEP_COUNTER(absolute_step_counter), .OUTPUTS_N(outs)
  );
  motor_model motor_model_inst (
    .clock(clock), .rst(rst), .step(step), .dir_neg(dneg),
    .origin_clear(st[MRST]), .pos(pos)
  );
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  // Fields go out with the strobe; the answer is read just past the edge.
  task automatic go(input int b, input run_req_t r = '0,
      input amp_req_t a = '0, input out_req_t o = '0);
    @(posedge clock);
    rr <= r;
    ar <= a;
    orq <= o;
    st[b] <= 1'b1;
    @(posedge clock);
    st <= '0;
    #1;
  endtask
  task automatic ap(input logic [12:0] a, input logic e,
      input logic [7:0] v);
    go(AMP, '0, a);
    chk(err, e, "amp error");
    chk(e ? code : amp, v, "amp result");
  endtask
  task automatic op(input logic [18:0] p, input logic bad, e,
      input logic [7:0] v);
    go(OUT, '0, '0, {p, bad, 36'h0});
    chk(err, e, "out error");
    chk(e ? code : outs, v, "out result");
  endtask
  task automatic steps(input int n);
    repeat (n) @(posedge step);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 40000 && moving; i++) @(posedge clock);
    // The motor model counts the last step one edge after the block.
    repeat (2) @(posedge clock);
    #1;
    chk(moving, 0, "still moving");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // A hang counts against the run instead of stalling it.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 99000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    sc <= 1'b1;
    @(posedge clock);
    sc <= 1'b0;
    #1;
    chk(outs, 8'hFF, "reset outputs");
    chk(amp, 8'h00, "reset amplitude");
    ap({3'b110, 10'h0FF}, 0, 8'hFF);
    ap({3'b110, 10'h100}, 1, ERR_RANGE);
    ap({3'b100, 10'h005}, 1, ERR_SYNTAX);
    ap({3'b111, 10'h005}, 1, ERR_SYNTAX);
    ap({3'b000, 10'h000}, 1, ERR_SYNTAX);
    chk(amp, 8'hFF, "amplitude kept");
    @(posedge clock) cp <= 1'b0;
    ap({3'b110, 10'h010}, 1, ERR_NO_CURRENT);
    @(posedge clock) cp <= 1'b1;
    fr <= 1'b1;
    @(posedge clock) fr <= 1'b0;
    #1;
    chk(amp, 8'h00, "restore amplitude");
    $display("test amplitude done");
    op({1'b1, 10'h0A5, 8'h0F}, 0, 0, 8'hF5);
    op({1'b1, 10'h000, 8'hF0}, 0, 0, 8'h05);
    op({1'b0, 10'h012, 8'hFF}, 0, 1, ERR_SYNTAX);
    op({1'b1, 10'h100, 8'hFF}, 0, 1, ERR_RANGE);
    op({1'b1, 10'h012, 8'hFF}, 1, 1, ERR_RANGE);
    chk(outs, 8'h05, "outputs kept");
    go(PON);
    chk(power, 1, "power on");
    chk(stby, 1, "idle standby");
    go(POFF);
    chk(power, 0, "power off");
    $display("test outputs and power done");
    go(RUN, {3'b111, 15'h4E1F});
    chk(power, 1, "auto power");
    steps(2);
    #1;
    chk(stby, 0, "rated current");
    chk(dneg, 1, "minus sign");
    go(RUN, {3'b110, 15'h4E1F});
    chk(refused, 0, "rerun accepted");
    go(HOME);
    chk(moving, 1, "home cannot end run");
    steps(1);
    #1;
    chk(dneg, 1, "sign ignored");
    go(STOP);
    chk(moving, 0, "stopped");
    chk(absolute_step_counter, pos, "counter vs motor");
    go(RUN);
    steps(1);
    #1;
    chk(dneg, 1, "last direction");
    go(DEC);
    wait_idle();
    go(HOME);
    chk(moving, 1, "home moves");
    go(RUN, {3'b100, 15'h4E1F});
    chk(refused, 1, "run refused");
    wait_idle();
    chk(absolute_step_counter, 0, "at origin");
    chk(pos, 0, "motor at origin");
    go(HOME);
    chk(moving, 0, "home at origin");
    go(RUN, {3'b100, 15'h4E20});
    chk(code, ERR_RANGE, "speed limit");
    chk(moving, 0, "bad speed idle");
    go(RUN);
    go(MRST);
    chk(moving, 0, "reset ends run");
    chk(outs, 8'hFF, "reset outputs");
    $display("test motion done");
    @(posedge clock) ms <= 1'b0;
    op({1'b1, 10'h000, 8'hFF}, 0, 0, 8'h00);
    go(RUN);
    go(RUN);
    chk(refused, 1, "full step rerun");
    steps(1);
    go(STOP);
    @(posedge clock);
    #1;
    chk(outs, 8'hFF, "outputs released");
    $display("test full step done");
    finish_test();
  end
endmodule // stepper_indexer_motion_commands_test
